// [design/wdc_top.sv]
// watchdog down counter with ahb-lite register slave
// assumes one 50 MHz clock, one ahb-lite master, zero-wait answers
`timescale 1ns/10ps
module wdc_top
	import wdc_pkg::*;
#(
	parameter logic [WDC_DIV_W-1:0] TICK_DIV = WDC_DIV_W'(WDC_OSC_DIV)
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        always_on_option,
	output logic             wdt_reset_req,
	output logic             wdt_irq_pulse,
	output logic             irq
);

	wdc_req_t            req;
	wdc_state_t          state;
	wdc_evt_t            status;
	wdc_evt_t            irq_en;
	logic [7:0]          reload_upper_byte;
	logic [7:0]          reload_high_byte;
	logic [7:0]          reload_low_byte;
	logic [WDC_CNT_W-1:0] count;
	logic                resp_int;
	logic                ao_meta;
	logic                ao_sync;
	logic                ao_seen;
	logic                tick;
	logic                addr_ok;
	logic                wr_now;
	logic                start_cmd;
	logic                feed_cmd;
	logic                feed_ok;
	logic                feed_refused;
	logic                expire;
	logic                running;
	logic [WDC_CNT_W-1:0] reload_value;
	logic [31:0]         next_hrdata;
	wdc_evt_t            clear_bits;

	assign reload_value = {reload_upper_byte, reload_high_byte, reload_low_byte};
	assign running      = (state == WDC_RUN);
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;

	// address phase
	assign addr_ok = hsel && hready && (htrans == WDC_HTRANS_NONSEQ || htrans == WDC_HTRANS_SEQ);
	assign wr_now  = req.valid && req.write;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req <= '0;
		end
		else if (hready)
		begin
			req.valid <= addr_ok;
			req.write <= hwrite;
			req.addr  <= haddr[7:0];
		end
	end

	// read data registered at the address phase, stands in the data phase
	always_comb
	begin
		next_hrdata = 32'h0000_0000;
		unique case (haddr[7:0])
			WDC_OFS_UPPER:  next_hrdata[7:0] = reload_upper_byte;
			WDC_OFS_HIGH:   next_hrdata[7:0] = reload_high_byte;
			WDC_OFS_LOW:    next_hrdata[7:0] = reload_low_byte;
			WDC_OFS_CTRL:
			begin
				next_hrdata[WDC_CTRL_RESP] = resp_int;
				next_hrdata[WDC_CTRL_ON]   = running;
				next_hrdata[WDC_CTRL_AO]   = ao_seen;
			end
			WDC_OFS_COUNT:  next_hrdata[WDC_CNT_W-1:0] = count;
			WDC_OFS_STATUS: next_hrdata[WDC_EVT_W-1:0] = status;
			WDC_OFS_IRQEN:  next_hrdata[WDC_EVT_W-1:0] = irq_en;
			default:        next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
		end
		else if (addr_ok && !hwrite)
		begin
			hrdata <= next_hrdata;
		end
	end

	// reload registers; software keeps the value at or above the minimum
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			reload_upper_byte <= WDC_RELOAD_RST;
			reload_high_byte  <= WDC_RELOAD_RST;
			reload_low_byte   <= WDC_RELOAD_RST;
		end
		else if (wr_now)
		begin
			if (req.addr == WDC_OFS_UPPER)
			begin
				reload_upper_byte <= hwdata[7:0];
			end
			if (req.addr == WDC_OFS_HIGH)
			begin
				reload_high_byte <= hwdata[7:0];
			end
			if (req.addr == WDC_OFS_LOW)
			begin
				reload_low_byte <= hwdata[7:0];
			end
		end
	end

	// response select
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			resp_int <= 1'b0;
		end
		else if (wr_now && req.addr == WDC_OFS_CTRL)
		begin
			resp_int <= hwdata[WDC_CTRL_RESP];
		end
	end

	assign start_cmd = wr_now && req.addr == WDC_OFS_CTRL && hwdata[WDC_CTRL_START];
	// a key guards against stray writes refreshing the counter
	assign feed_cmd  = wr_now && req.addr == WDC_OFS_FEED && hwdata == WDC_FEED_KEY;
	assign feed_ok      = feed_cmd && running && (count > WDC_NO_REFRESH);
	assign feed_refused = feed_cmd && running && (count <= WDC_NO_REFRESH);

	// option pin synchroniser
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ao_meta <= 1'b0;
			ao_sync <= 1'b0;
		end
		else
		begin
			ao_meta <= always_on_option;
			ao_sync <= ao_meta;
		end
	end

	// option latched once it is seen after reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ao_seen <= 1'b0;
		end
		else if (ao_sync)
		begin
			ao_seen <= 1'b1;
		end
	end

	wdc_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (running),
		.tick    (tick)
	);

	// one count per oscillator cycle, so timeout in ms is reload / 10
	assign expire = running && tick && (count == WDC_CNT_W'(1));

	// off/run/expired state; back to off only through reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= WDC_OFF;
		end
		else
		begin
			unique case (state)
				WDC_OFF:
				begin
					if (start_cmd || ao_sync)
					begin
						state <= WDC_RUN;
					end
				end
				WDC_RUN:
				begin
					if (expire && !resp_int)
					begin
						state <= WDC_EXPIRED;
					end
				end
				WDC_EXPIRED:
				begin
					state <= WDC_EXPIRED;
				end
				default:
				begin
					state <= WDC_OFF;
				end
			endcase
		end
	end

	// down counter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count <= '0;
		end
		else if (state == WDC_OFF && (start_cmd || ao_sync))
		begin
			count <= reload_value;
		end
		else if (running)
		begin
			if (feed_ok)
			begin
				count <= reload_value;
			end
			else if (expire)
			begin
				count <= resp_int ? reload_value : '0;
			end
			else if (tick)
			begin
				count <= count - WDC_CNT_W'(1);
			end
		end
	end

	// expiry outputs: reset level holds until system reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wdt_reset_req <= 1'b0;
			wdt_irq_pulse <= 1'b0;
		end
		else
		begin
			wdt_irq_pulse <= expire && resp_int;
			if (expire && !resp_int)
			begin
				wdt_reset_req <= 1'b1;
			end
		end
	end

	// event flags
	always_comb
	begin
		clear_bits = '0;
		if (wr_now && req.addr == WDC_OFS_CLEAR)
		begin
			clear_bits = wdc_evt_t'(hwdata[WDC_EVT_W-1:0]);
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status <= '0;
		end
		else
		begin
			status.timeout <= expire || (status.timeout && !clear_bits.timeout);
			status.refused <= feed_refused || (status.refused && !clear_bits.refused);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_en <= '0;
		end
		else if (wr_now && req.addr == WDC_OFS_IRQEN)
		begin
			irq_en <= wdc_evt_t'(hwdata[WDC_EVT_W-1:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(status & irq_en);
		end
	end

	logic unused_hsize;
	assign unused_hsize = ^hsize;

endmodule

// [design/wdc_pkg.sv]
// constants, register map and carrier types for the watchdog down counter
// assumes a single 50 MHz bus clock; the oscillator tick is derived from it
package wdc_pkg;

	localparam int unsigned WDC_CLK_HZ     = 50_000_000;
	localparam int unsigned WDC_OSC_HZ     = 10_000;
	localparam int unsigned WDC_OSC_DIV    = WDC_CLK_HZ / WDC_OSC_HZ;
	localparam int unsigned WDC_DIV_W      = 16;

	localparam int unsigned WDC_CNT_W      = 24;
	localparam int unsigned WDC_BYTE_W     = 8;
	localparam logic [23:0] WDC_NO_REFRESH = 24'h000002;
	localparam logic [23:0] WDC_MIN_RELOAD = 24'h000004;
	localparam logic [7:0]  WDC_RELOAD_RST = 8'hff;

	localparam logic [7:0] WDC_OFS_UPPER  = 8'h00;
	localparam logic [7:0] WDC_OFS_HIGH   = 8'h04;
	localparam logic [7:0] WDC_OFS_LOW    = 8'h08;
	localparam logic [7:0] WDC_OFS_CTRL   = 8'h0c;
	localparam logic [7:0] WDC_OFS_FEED   = 8'h10;
	localparam logic [7:0] WDC_OFS_COUNT  = 8'h14;
	localparam logic [7:0] WDC_OFS_STATUS = 8'h18;
	localparam logic [7:0] WDC_OFS_IRQEN  = 8'h1c;
	localparam logic [7:0] WDC_OFS_CLEAR  = 8'h20;

	localparam int unsigned WDC_CTRL_RESP  = 0;
	localparam int unsigned WDC_CTRL_START = 1;
	localparam int unsigned WDC_CTRL_ON    = 2;
	localparam int unsigned WDC_CTRL_AO    = 3;

	localparam int unsigned WDC_EVT_W       = 2;
	localparam int unsigned WDC_EVT_TIMEOUT = 0;
	localparam int unsigned WDC_EVT_REFUSED = 1;
	localparam logic [31:0] WDC_FEED_KEY    = 32'h0000_00a5;

	localparam logic [1:0] WDC_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] WDC_HTRANS_SEQ    = 2'b11;

	typedef enum logic [1:0]
	{
		WDC_OFF     = 2'b00,
		WDC_RUN     = 2'b01,
		WDC_EXPIRED = 2'b10
	} wdc_state_t;

	typedef struct packed
	{
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} wdc_req_t;

	typedef struct packed
	{
		logic refused;
		logic timeout;
	} wdc_evt_t;

endpackage

// [design/wdc_tick.sv]
// divider standing in for the dedicated watchdog oscillator
// assumes the bus clock; emits one-cycle tick every div cycles
`timescale 1ns/10ps
module wdc_tick
	import wdc_pkg::*;
#(
	parameter logic [WDC_DIV_W-1:0] DIV = WDC_DIV_W'(WDC_OSC_DIV)
)
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic run,
	output logic      tick
);

	logic [WDC_DIV_W-1:0] div_cnt;

	// counter held at zero while off so the first period is whole
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end
		else if (!run)
		begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end
		else if (div_cnt == DIV - WDC_DIV_W'(1))
		begin
			div_cnt <= '0;
			tick    <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + WDC_DIV_W'(1);
			tick    <= 1'b0;
		end
	end

endmodule

// [dv/wdc_top_props.sv]
// port-level checker for the watchdog down counter
// assumes the zero-wait ahb-lite slave and the wdc_pkg register map
`timescale 1ns/10ps
module wdc_top_props
	import wdc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        always_on_option,
	input wire logic        wdt_reset_req,
	input wire logic        wdt_irq_pulse,
	input wire logic        irq
);
	logic       rd_q;
	logic [7:0] a_q;
	logic       on_q;
	logic [2:0] ao_n;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_q <= 1'b0;
		else if (hready)
			rd_q <= hsel && htrans[1] && !hwrite;
	end
	always_ff @(posedge hclk)
	begin
		if (hready)
			a_q <= haddr[7:0];
	end
	// once seen running it may only stop while a reset request is pending
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			on_q <= 1'b0;
		else if (rd_q && a_q == WDC_OFS_CTRL && hrdata[2])
			on_q <= 1'b1;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ao_n <= 3'h0;
		else if (!always_on_option)
			ao_n <= 3'h0;
		else if (ao_n != 3'h7)
			ao_n <= ao_n + 3'h1;
	end
	property p_hold; $rose(wdt_reset_req) |=> wdt_reset_req [*8]; endproperty
	a_hold: assert property (p_hold)
		else $error("reset request dropped");
	property p_pulse; wdt_irq_pulse |=> !wdt_irq_pulse; endproperty
	a_pulse: assert property (p_pulse)
		else $error("interrupt pulse too long");
	property p_excl; wdt_irq_pulse |-> !wdt_reset_req; endproperty
	a_excl: assert property (p_excl)
		else $error("both responses active");
	property p_rld; rd_q && a_q < WDC_OFS_CTRL |-> hrdata[31:8] == 24'h0; endproperty
	a_rld: assert property (p_rld)
		else $error("reload byte too wide");
	property p_cnt; rd_q && a_q == WDC_OFS_COUNT |-> hrdata[31:24] == 8'h0; endproperty
	a_cnt: assert property (p_cnt)
		else $error("count wider than 24 bits");
	property p_ctl; rd_q && a_q == WDC_OFS_CTRL |-> !hrdata[1] && hrdata[31:4] == 28'h0; endproperty
	a_ctl: assert property (p_ctl)
		else $error("start bit reads back");
	// a pending reset request stands for the device reset, so running may drop then
	property p_on; rd_q && a_q == WDC_OFS_CTRL && on_q && !wdt_reset_req |-> hrdata[2]; endproperty
	a_on: assert property (p_on)
		else $error("watchdog switched off");
	property p_ao; rd_q && a_q == WDC_OFS_CTRL && ao_n == 3'h7 |-> hrdata[3:2] == 2'b11; endproperty
	a_ao: assert property (p_ao)
		else $error("always-on not running");
endmodule
bind wdc_top wdc_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.always_on_option(always_on_option), .wdt_reset_req(wdt_reset_req),
	.wdt_irq_pulse(wdt_irq_pulse), .irq(irq));

// [dv/wdc_top_tb_top.sv]
// self-checking bench for the watchdog down counter
// assumes wdc_top with its tick divider shortened to 4
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module wdc_top_tb_top import wdc_pkg::*;;
	logic        hclk, hresetn, hsel, hwrite, ao, rdy, rreq, ipul, irq, rsp;
	logic [31:0] haddr, hwdata, r, r_in;
	logic [1:0]  htrans;
	int          fail_count, checks, c;
	wdc_top #(.TICK_DIV(16'd4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(rdy), .hreadyout(rdy), .hresp(rsp), .hrdata(r_in), .always_on_option(ao),
		.wdt_reset_req(rreq), .wdt_irq_pulse(ipul), .irq(irq));
	always #10 hclk = ~hclk;
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic hang;
		fail_count++;
		report_and_stop;
	endtask
	task automatic wr;
		int n;
		n = 0;
		@(posedge hclk);
		while (rdy !== 1'b1)
		begin
			if (++n > 50)
				hang;
			@(posedge hclk);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= WDC_HTRANS_NONSEQ;
		wr;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wr;
		r = r_in;
	endtask
	task automatic wt(input bit k, input int lim);
		c = 0;
		while ((k ? ipul : rreq) !== 1'b1)
		begin
			@(posedge hclk);
			if (++c > lim)
				hang;
		end
	endtask
	task automatic rst(input logic o);
		hresetn <= 1'b0;
		ao <= o;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 3; i++)
		begin
			xf(0, 8'(4 * i), 0);
			`CHK("reload", 32'hff, r)
		end
		xf(1, 8'h24, 32'h1);
		xf(0, 8'h24, 0);
		`CHK("unmapped", 32'h0, r)
		`CHK("okay", 1'b0, rsp)
		xf(0, WDC_OFS_COUNT, 0);
		`CHK("idle_count", 32'h0, r)
	endtask
	task automatic t_rmode;
		xf(1, WDC_OFS_UPPER, 32'h1);
		xf(1, WDC_OFS_HIGH, 32'h2);
		xf(1, WDC_OFS_LOW, 32'h3);
		xf(1, WDC_OFS_CTRL, 32'h2);
		xf(0, WDC_OFS_COUNT, 0);
		`CHK("load", 32'h10203, r)
		xf(1, WDC_OFS_UPPER, 0);
		xf(1, WDC_OFS_HIGH, 0);
		xf(1, WDC_OFS_LOW, 32'h6);
		xf(1, WDC_OFS_FEED, WDC_FEED_KEY);
		xf(0, WDC_OFS_COUNT, 0);
		`CHK("refresh", 1'b1, r == 6 || r == 5)
		wt(0, 60);
		`CHK("timeout", 1'b1, c >= 19 && c <= 24)
		xf(0, WDC_OFS_STATUS, 0);
		`CHK("status", 32'h1, r)
	endtask
	task automatic t_irq;
		rst(0);
		xf(1, WDC_OFS_CTRL, 32'h1);
		xf(1, WDC_OFS_IRQEN, 32'h1);
		xf(1, WDC_OFS_UPPER, 0);
		xf(1, WDC_OFS_HIGH, 0);
		xf(1, WDC_OFS_LOW, 32'h4);
		xf(1, WDC_OFS_CTRL, 32'h3);
		wt(1, 40);
		`CHK("no_reset", 1'b0, rreq)
		repeat (2) @(posedge hclk);
		`CHK("irq", 1'b1, irq)
		xf(1, WDC_OFS_CLEAR, 32'h1);
		// irq is registered one edge behind status
		repeat (2) @(posedge hclk);
		`CHK("irq_clr", 1'b0, irq)
		xf(1, WDC_OFS_IRQEN, 0);
		wt(1, 40);
		repeat (2) @(posedge hclk);
		`CHK("masked", 1'b0, irq)
		xf(1, WDC_OFS_IRQEN, 32'h1);
		repeat (2) @(posedge hclk);
		`CHK("unmask", 1'b1, irq)
		// poll so the refresh lands while the count sits at two or one
		r = 0;
		for (int i = 0; i < 20 && r !== 32'h2; i++)
			xf(0, WDC_OFS_COUNT, 0);
		`CHK("reach2", 32'h2, r)
		xf(1, WDC_OFS_FEED, WDC_FEED_KEY);
		xf(0, WDC_OFS_STATUS, 0);
		`CHK("refused", 1'b1, r[1])
		xf(0, WDC_OFS_CTRL, 0);
		`CHK("ctrl", 32'h5, r)
	endtask
	task automatic t_ao;
		rst(1);
		repeat (6) @(posedge hclk);
		for (int i = 0; i < 2; i++)
		begin
			xf(0, WDC_OFS_CTRL, 0);
			`CHK("ao_ctrl", 32'hc, r)
		end
		xf(0, WDC_OFS_COUNT, 0);
		`CHK("ao_count", 16'hffff, r[23:8])
		`CHK("ao_runs", 1'b1, r[23:0] < 24'hffffff)
	endtask
	initial
	begin
		hclk = 0;
		hresetn = 0;
		hsel = 0;
		haddr = 0;
		htrans = 0;
		hwrite = 0;
		hwdata = 0;
		ao = 0;
		fail_count = 0;
		checks = 0;
		r = 0;
		rst(0);
		t_regs;
		t_rmode;
		t_irq;
		t_ao;
		report_and_stop;
	end
endmodule
